// ==== rtl/scgs_pkg.sv ====
// constants, types and register map of the clock generation and select unit
package scgs_pkg;
  // register byte offsets
  localparam logic [7:0] SCGS_OFF_RWL = 8'h00;
  localparam logic [7:0] SCGS_OFF_RWH = 8'h04;
  localparam logic [7:0] SCGS_OFF_OCC = 8'h08;
  localparam logic [7:0] SCGS_OFF_UCR = 8'h0C;
  localparam logic [7:0] SCGS_OFF_LCR = 8'h10;
  localparam logic [7:0] SCGS_OFF_STS = 8'h14;
  localparam logic [7:0] SCGS_OFF_RAT = 8'h18;
  // low reset word fields
  localparam int SCGS_SYSTEM_PLL_MULT_LSB = 24;
  localparam int SCGS_SYSTEM_PLL_MULT_W = 4;
  localparam int SCGS_CORE_LSB = 16;
  localparam int SCGS_CORE_W = 7;
  localparam int SCGS_ENGINE_PLL_MULT_LSB = 8;
  localparam int SCGS_ENGINE_PLL_MULT_W = 5;
  localparam int SCGS_ENGINE_PLL_DIV_BIT = 7;
  localparam int SCGS_VCOD_LSB = 4;
  localparam int SCGS_VCOD_W = 2;
  localparam int SCGS_MEM1CM_BIT = 1;
  localparam int SCGS_LOCALBUS_CLOCK_MODE_BIT = 0;
  // high reset word fields
  localparam int SCGS_HOST_BIT = 31;
  localparam int SCGS_CKDRV_BIT = 30;
  // unit clock control fields
  localparam int SCGS_SEC_LSB = 0;
  localparam int SCGS_BUS_BIT = 2;
  localparam int SCGS_NOUT = 5;
  localparam int SCGS_DIV_W = 4;
  localparam int SCGS_RATIO_W = 16;
  // reset values: arbitrary plain defaults
  localparam logic [31:0] SCGS_RWL_RST = 32'h0402_0900;
  localparam logic [31:0] SCGS_RWH_RST = 32'hC000_0000;
  localparam logic [SCGS_NOUT-1:0] SCGS_OCC_RST = 5'h00;
  localparam logic [SCGS_DIV_W-1:0] SCGS_LCR_RST = 4'h2;
  // engine multiplier codes
  localparam logic [4:0] SCGS_ENGINE_PLL_MULT_X16 = 5'h00;
  localparam logic [4:0] SCGS_ENGINE_PLL_MULT_RSVD = 5'h01;
  localparam logic [SCGS_RATIO_W-1:0] SCGS_X16 = 16'h0010;
  localparam logic [31:0] SCGS_FULL_MAX_MHZ = 32'h0000_00A6; // 166 MHz
  typedef enum logic [1:0] {SCGS_SEC_OFF, SCGS_SEC_FULL, SCGS_SEC_HALF,
                            SCGS_SEC_THIRD} scgs_sec_t;
  localparam logic [1:0] SCGS_UCR_RST = 2'h3; // third only; the bus on bit is reset separately
  typedef enum {SCGS_SRC_OSC, SCGS_SRC_BUS, SCGS_SRC_SYNC} scgs_src_t;
endpackage : scgs_pkg

// ==== rtl/scgs_div_if.sv ====
// divider control bundle between top and divider instances
`timescale 1ns/10ps
interface scgs_div_if;
  logic enable;
  logic [3:0] ratio;
  logic tick;
  modport ctl (output enable, output ratio, input tick);
  modport div (input enable, input ratio, output tick);
endinterface : scgs_div_if

// ==== rtl/scgs_div.sv ====
// enabled ratio divider producing a square clock-like level
`timescale 1ns/10ps
module scgs_div
  import scgs_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, low
  scgs_div_if.div dif // control bundle
);
  logic [3:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  always_comb begin
    cnt_d = cnt_q;
    tick_d = tick_q;
    if (!dif.enable || dif.ratio == 4'h0) begin
      cnt_d = 4'h0;
      tick_d = 1'b0;
    end else if (cnt_q + 4'h1 >= dif.ratio) begin
      cnt_d = 4'h0;
      tick_d = ~tick_q;
    end else begin
      cnt_d = cnt_q + 4'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
  assign dif.tick = tick_q;
endmodule : scgs_div

// ==== rtl/scgs_top.sv ====
// clock generation and select unit: straps, ratios, enables, dividers
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
module scgs_top
  import scgs_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, low
  input wire logic primary_osc_in, // oscillator level
  input wire logic bus_clk_in, // agent bus clock level
  input wire logic sync_clk_in, // looped sync clock level
  input wire logic input_halve_strap, // halve oscillator strap
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hsel, // ahb select
  input wire logic hready, // ahb bus ready
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb ready out
  output logic hresp, // ahb response
  output logic sync_clk_out, // sync clock output
  output logic [SCGS_NOUT-1:0] bus_clock_out_n, // bus clock outputs
  output logic [SCGS_NOUT-1:0] bus_clock_out_en_n, // output enables, low drives
  output logic primary_clk, // selected primary clock
  output logic [1:0] primary_src, // selected source code
  output logic sec_clk, // security core clock
  output logic dma_clk_en, // bus and dma complex clock on
  output logic mem1_bus_clock_out, // halved memory bus clock
  output logic localbus_clock_out, // divided local bus clock
  output logic engine_clk_en, // engine clock active
  output logic cfg_invalid // reserved engine code loaded
);
  logic [31:0] rwl_q, rwl_d, rwh_q, rwh_d;
  logic [SCGS_NOUT-1:0] occ_q, occ_d;
  logic [1:0] sec_q, sec_d;
  logic bus_on_q, bus_on_d;
  logic [SCGS_DIV_W-1:0] lcr_q, lcr_d;
  logic ap_q, ap_d, apw_q, apw_d;
  logic [7:0] apa_q, apa_d;
  logic [31:0] rd_q, rd_d;
  logic [SCGS_RATIO_W-1:0] sys_r_q, sys_r_d, core_r_q, core_r_d, eng_r_q, eng_r_d;
  logic [SCGS_RATIO_W-1:0] mem_r_q, mem_r_d, lb_r_q, lb_r_d, vco_r_q, vco_r_d;
  logic [31:0] in_mhz;
  logic host, ckdrv, sec_full_ok;
  logic [4:0] engine_pll_mult;
  logic engine_pll_div;
  scgs_src_t src;
  logic pclk_d, sclk_d, half_q, half_d, sec_cnt_d, memh_d;
  logic [1:0] sec_cnt_q, sec_cnt_n;
  logic pclk_q, sclk_q, sec_clk_q, memh_q;
  logic osc_q, osc_d;
  logic [SCGS_NOUT-1:0] bco_d, bce_d;
  logic cfg_bad;
  scgs_div_if lb_if ();
  scgs_div_if sec_if ();

  assign host = rwh_q[SCGS_HOST_BIT];
  assign ckdrv = rwh_q[SCGS_CKDRV_BIT];
  assign engine_pll_mult = rwl_q[SCGS_ENGINE_PLL_MULT_LSB +: SCGS_ENGINE_PLL_MULT_W];
  assign engine_pll_div = rwl_q[SCGS_ENGINE_PLL_DIV_BIT];
  // source selection from straps
  always_comb begin
    if (host && ckdrv) src = SCGS_SRC_OSC;
    else if (host) src = SCGS_SRC_SYNC;
    else src = SCGS_SRC_BUS;
  end

  // ahb slave: one wait-free data phase, always okay
  always_comb begin
    ap_d = hsel && hready && htrans[1];
    apw_d = hwrite;
    apa_d = haddr[7:0];
    rwl_d = rwl_q;
    rwh_d = rwh_q;
    occ_d = occ_q;
    sec_d = sec_q;
    bus_on_d = bus_on_q;
    lcr_d = lcr_q;
    rd_d = 32'h0000_0000;
    if (ap_q && apw_q) begin
      unique case (apa_q)
        SCGS_OFF_RWL: rwl_d = hwdata;
        SCGS_OFF_RWH: rwh_d = hwdata;
        SCGS_OFF_OCC: occ_d = hwdata[SCGS_NOUT-1:0];
        SCGS_OFF_UCR: begin
          if (hwdata[1:0] != SCGS_SEC_FULL || sec_full_ok)
            sec_d = hwdata[SCGS_SEC_LSB +: 2];
          bus_on_d = hwdata[SCGS_BUS_BIT];
        end
        SCGS_OFF_LCR: lcr_d = hwdata[SCGS_DIV_W-1:0];
        default: ;
      endcase
    end
    if (ap_d && !hwrite) begin
      unique case (haddr[7:0])
        SCGS_OFF_RWL: rd_d = rwl_q;
        SCGS_OFF_RWH: rd_d = rwh_q;
        SCGS_OFF_OCC: rd_d = {27'h0000000, occ_q};
        SCGS_OFF_UCR: rd_d = {29'h00000000, bus_on_q, sec_q};
        SCGS_OFF_LCR: rd_d = {28'h0000000, lcr_q};
        SCGS_OFF_STS: rd_d = {27'h0000000, cfg_bad, engine_clk_en, src == SCGS_SRC_SYNC,
                              src == SCGS_SRC_BUS, src == SCGS_SRC_OSC};
        SCGS_OFF_RAT: rd_d = {sys_r_q, eng_r_q};
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  // ratio computation relative to primary input
  always_comb begin
    sys_r_d = SCGS_RATIO_W'(({15'h0000, input_halve_strap} + 16'h0001)
              * rwl_q[SCGS_SYSTEM_PLL_MULT_LSB +: SCGS_SYSTEM_PLL_MULT_W]);
    core_r_d = SCGS_RATIO_W'(sys_r_q * rwl_q[SCGS_CORE_LSB +: SCGS_CORE_W]);
    if (engine_pll_mult == SCGS_ENGINE_PLL_MULT_X16) eng_r_d = engine_pll_div ? (SCGS_X16 >> 1) : SCGS_X16;
    else eng_r_d = SCGS_RATIO_W'({11'h000, engine_pll_mult} >> engine_pll_div);
    if (engine_pll_mult == SCGS_ENGINE_PLL_MULT_RSVD) eng_r_d = 16'h0000;
    vco_r_d = SCGS_RATIO_W'(eng_r_q * ({14'h0000, rwl_q[SCGS_VCOD_LSB +: SCGS_VCOD_W]})
              * ({15'h0000, engine_pll_div} + 16'h0001));
    mem_r_d = rwl_q[SCGS_MEM1CM_BIT] ? SCGS_RATIO_W'(sys_r_q << 1) : sys_r_q;
    lb_r_d = rwl_q[SCGS_LOCALBUS_CLOCK_MODE_BIT] ? SCGS_RATIO_W'(sys_r_q << 1) : sys_r_q;
  end
  assign cfg_bad = engine_pll_mult == SCGS_ENGINE_PLL_MULT_RSVD;
  // input frequency estimate: 33 MHz per input step, conservative
  assign in_mhz = 32'(sys_r_q) * 32'h0000_0021;
  assign sec_full_ok = in_mhz <= SCGS_FULL_MAX_MHZ;

  // clock level paths
  always_comb begin
    unique case (src)
      SCGS_SRC_OSC: pclk_d = primary_osc_in;
      SCGS_SRC_BUS: pclk_d = bus_clk_in;
      SCGS_SRC_SYNC: pclk_d = sync_clk_in;
    endcase
    // halving toggle on oscillator rise
    // level samples: toggling on every high sample would not halve
    osc_d = primary_osc_in;
    half_d = (primary_osc_in && !osc_q) ? ~half_q : half_q;
    sclk_d = input_halve_strap ? half_q : primary_osc_in;
    bco_d = '0;
    bce_d = '1;
    for (int i = 0; i < SCGS_NOUT; i++) begin
      if (src == SCGS_SRC_OSC && occ_q[i]) begin
        bco_d[i] = half_q;
        bce_d[i] = 1'b0;
      end
    end
    sec_cnt_n = (sec_q == SCGS_SEC_THIRD && sec_cnt_q == 2'h2) ? 2'h0 : sec_cnt_q + 2'h1;
    unique case (sec_q)
      SCGS_SEC_OFF: sec_cnt_d = 1'b0;
      SCGS_SEC_FULL: sec_cnt_d = ~sec_clk_q;
      SCGS_SEC_HALF: sec_cnt_d = sec_if.tick;
      SCGS_SEC_THIRD: sec_cnt_d = (sec_cnt_q == 2'h2) ? ~sec_clk_q : sec_clk_q;
    endcase
    memh_d = ~memh_q;
  end

  assign lb_if.enable = 1'b1;
  assign lb_if.ratio = lcr_q;
  assign sec_if.enable = sec_q == SCGS_SEC_HALF;
  // full toggles each cycle, so half holds each level two cycles
  assign sec_if.ratio = 4'h2;
  scgs_div u_lbdiv (.hclk(hclk), .hresetn(hresetn), .dif(lb_if.div));
  scgs_div u_secdiv (.hclk(hclk), .hresetn(hresetn), .dif(sec_if.div));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rwl_q <= SCGS_RWL_RST;
      rwh_q <= SCGS_RWH_RST;
      occ_q <= SCGS_OCC_RST;
      sec_q <= SCGS_SEC_THIRD;
      bus_on_q <= 1'b1;
      lcr_q <= SCGS_LCR_RST;
      ap_q <= 1'b0;
      apw_q <= 1'b0;
      apa_q <= 8'h00;
      rd_q <= 32'h0000_0000;
      {sys_r_q, core_r_q, eng_r_q, vco_r_q, mem_r_q, lb_r_q} <= '0;
      {pclk_q, sclk_q, half_q, sec_clk_q, memh_q, osc_q} <= '0;
      sec_cnt_q <= 2'h0;
      bus_clock_out_n <= '0;
      bus_clock_out_en_n <= '1;
      localbus_clock_out <= 1'b0;
      engine_clk_en <= 1'b0;
      cfg_invalid <= 1'b0;
      dma_clk_en <= 1'b0;
      primary_src <= 2'h0;
    end else begin
      rwl_q <= rwl_d;
      rwh_q <= rwh_d;
      occ_q <= occ_d;
      sec_q <= sec_d;
      bus_on_q <= bus_on_d;
      lcr_q <= lcr_d;
      ap_q <= ap_d;
      apw_q <= apw_d;
      apa_q <= apa_d;
      rd_q <= rd_d;
      sys_r_q <= sys_r_d;
      core_r_q <= core_r_d;
      eng_r_q <= eng_r_d;
      vco_r_q <= vco_r_d;
      mem_r_q <= mem_r_d;
      lb_r_q <= lb_r_d;
      pclk_q <= pclk_d;
      sclk_q <= sclk_d;
      half_q <= half_d;
      osc_q <= osc_d;
      sec_clk_q <= sec_cnt_d;
      memh_q <= memh_d;
      sec_cnt_q <= sec_cnt_n;
      bus_clock_out_n <= bco_d;
      bus_clock_out_en_n <= bce_d;
      localbus_clock_out <= lb_if.tick;
      engine_clk_en <= !cfg_bad;
      cfg_invalid <= cfg_bad;
      dma_clk_en <= bus_on_q;
      primary_src <= 2'(src);
    end
  end
  assign hrdata = rd_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign primary_clk = pclk_q;
  assign sync_clk_out = sclk_q;
  assign sec_clk = sec_clk_q;
  assign mem1_bus_clock_out = memh_q;

  property p_out_gate;
    @(posedge hclk) disable iff (!hresetn) !bus_clock_out_en_n[0] |-> $past(occ_q[0]);
  endproperty
  a_out_gate: assert property (p_out_gate) else $error("output driven while disabled");
  property p_no_drive;
    @(posedge hclk) disable iff (!hresetn) $past(host && !ckdrv) |-> &bus_clock_out_en_n;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("drive without strap");
  property p_rsvd;
    @(posedge hclk) disable iff (!hresetn) ##1 $past(cfg_bad) |-> cfg_invalid && !engine_clk_en;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code not flagged");
  property p_x16;
    @(posedge hclk) disable iff (!hresetn) $past(engine_pll_mult == SCGS_ENGINE_PLL_MULT_X16 && !engine_pll_div)
      |-> eng_r_q == SCGS_X16;
  endproperty
  a_x16: assert property (p_x16) else $error("code zero not sixteen");
  // system ratio
  // first edge after release still shows reset ratios
  property p_sys;
    @(posedge hclk) disable iff (!hresetn) $past(hresetn) |-> 32'(sys_r_q)
      == (32'($past(rwl_q[SCGS_SYSTEM_PLL_MULT_LSB +: SCGS_SYSTEM_PLL_MULT_W])) << $past(input_halve_strap));
  endproperty
  a_sys: assert property (p_sys) else $error("system ratio stale");
  property p_mem;
    @(posedge hclk) disable iff (!hresetn) $past(hresetn) |-> 32'(mem_r_q)
      == (32'($past(sys_r_q)) << $past(rwl_q[SCGS_MEM1CM_BIT]));
  endproperty
  a_mem: assert property (p_mem) else $error("memory ratio wrong");
  property p_lb;
    @(posedge hclk) disable iff (!hresetn) $past(hresetn) |-> 32'(lb_r_q)
      == (32'($past(sys_r_q)) << $past(rwl_q[SCGS_LOCALBUS_CLOCK_MODE_BIT]));
  endproperty
  a_lb: assert property (p_lb) else $error("local bus ratio wrong");
  property p_core;
    @(posedge hclk) disable iff (!hresetn) $past(hresetn) |-> 32'(core_r_q)
      == 32'($past(sys_r_q)) * 32'($past(rwl_q[SCGS_CORE_LSB +: SCGS_CORE_W]));
  endproperty
  a_core: assert property (p_core) else $error("core ratio wrong");
  property p_vco;
    @(posedge hclk) disable iff (!hresetn) $past(hresetn) |-> 32'(vco_r_q)
      == 32'($past(eng_r_q)) * 32'($past(rwl_q[SCGS_VCOD_LSB +: SCGS_VCOD_W]))
      * (32'h0000_0001 + 32'($past(engine_pll_div)));
  endproperty
  a_vco: assert property (p_vco) else $error("vco ratio wrong");
  property p_full;
    @(posedge hclk) disable iff (!hresetn) sec_q == SCGS_SEC_FULL
      |-> sec_full_ok || $past(sec_full_ok);
  endproperty
  a_full: assert property (p_full) else $error("full rate above limit");
  property p_osc;
    @(posedge hclk) disable iff (!hresetn) host && ckdrv |=> primary_src == 2'(SCGS_SRC_OSC);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator not selected");
endmodule : scgs_top

// ==== verification/scgs_board_model.sv ====
// board side: oscillator, agent bus clock and sync loopback
`timescale 1ns/10ps
module scgs_board_model (
  input wire logic hclk, // system clock
  input wire logic agent, // board strapped as agent
  input wire logic sync_clk_out, // device sync output
  output logic primary_osc_in, // oscillator level
  output logic bus_clk_in, // agent bus clock level
  output wire logic sync_clk_in // looped sync clock
);
  int k = 0;
  initial begin
    primary_osc_in = 1'b0;
    bus_clk_in = 1'b0;
  end
  always @(posedge hclk) begin
    k <= k + 1;
    primary_osc_in <= agent ? 1'b0 : k[1];
    bus_clk_in <= (k % 6) < 3;
  end
  assign sync_clk_in = sync_clk_out;
endmodule : scgs_board_model

// ==== verification/scgs_tb_top.sv ====
// self-checking bench of the clock generation and select unit
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module scgs_tb_top;
  import scgs_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, agent = 1'b0, halve = 1'b0, hwrite = 1'b0, hsel = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  wire logic osc, bck, syi;
  logic [31:0] hrdata;
  logic hreadyout, hresp, sync_clk_out, primary_clk, sec_clk, dma_clk_en;
  logic mem1_o, lb_o, eng_en, bad;
  logic [SCGS_NOUT-1:0] bco, bco_en_n;
  logic [1:0] primary_src;
  int err_total = 0, checked = 0, c;
  initial forever #5 hclk = ~hclk;
  scgs_board_model board (.hclk(hclk), .agent(agent), .sync_clk_out(sync_clk_out),
    .primary_osc_in(osc), .bus_clk_in(bck), .sync_clk_in(syi));
  scgs_top dut (.hclk(hclk), .hresetn(hresetn), .primary_osc_in(osc), .bus_clk_in(bck),
    .sync_clk_in(syi), .input_halve_strap(halve), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sync_clk_out(sync_clk_out),
    .bus_clock_out_n(bco), .bus_clock_out_en_n(bco_en_n), .primary_clk(primary_clk),
    .primary_src(primary_src), .sec_clk(sec_clk), .dma_clk_en(dma_clk_en),
    .mem1_bus_clock_out(mem1_o), .localbus_clock_out(lb_o), .engine_clk_en(eng_en),
    .cfg_invalid(bad));
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge hclk);
    end
    if (n >= 50) begin
      err_total++;
      summarize();
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : bus
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : cyc
  // counts level changes of one watched output over n cycles
  task automatic cnt(input int sel, input int n);
    logic p, v;
    c = 0;
    p = 1'b0;
    for (int i = 0; i <= n; i++) begin
      @(posedge hclk);
      #1;
      case (sel)
        0: v = sync_clk_out;
        1: v = bco[0];
        2: v = bco[1];
        3: v = lb_o;
        4: v = mem1_o;
        default: v = sec_clk;
      endcase
      if (i > 0 && v !== p) c++;
      p = v;
    end
  endtask : cnt
  task automatic follow(input logic [1:0] src);
    logic p;
    for (int i = 0; i < 8; i++) begin
      p = (src == 2'h0) ? osc : (src == 2'h1) ? bck : syi;
      cyc(1);
      `CHK("primary_clk", p, primary_clk)
    end
  endtask : follow
  task automatic t_reset;
    logic [7:0] a [6] = '{SCGS_OFF_RWL, SCGS_OFF_RWH, SCGS_OFF_OCC, SCGS_OFF_UCR,
      SCGS_OFF_LCR, 8'h1C};
    logic [31:0] e [6] = '{SCGS_RWL_RST, SCGS_RWH_RST, 32'h0, 32'h7, 32'h2, 32'h0};
    `CHK("en_n", 5'h1F, bco_en_n)
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, a[i], 32'h0);
      `CHK("reset reg", e[i], rd)
    end
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
    bus(1'b0, 8'h1C, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("t_reset done");
  endtask : t_reset
  task automatic t_source;
    logic [31:0] w [3] = '{32'hC000_0000, 32'h4000_0000, 32'h8000_0000};
    bus(1'b1, SCGS_OFF_OCC, 32'h1F);
    for (int i = 0; i < 3; i++) begin
      agent <= (i == 1);
      bus(1'b1, SCGS_OFF_RWH, w[i]);
      cyc(3);
      `CHK("primary_src", i[1:0], primary_src)
      follow(i[1:0]);
    end
    `CHK("en_n off", 5'h1F, bco_en_n)
    cnt(1, 20);
    `CHK("bus clk idle", 0, c)
    agent <= 1'b0;
    $display("t_source done");
  endtask : t_source
  task automatic t_enables;
    bus(1'b1, SCGS_OFF_RWH, 32'hC000_0000);
    bus(1'b1, SCGS_OFF_OCC, 32'h05);
    cyc(3);
    `CHK("en_n", 5'h1A, bco_en_n)
    cnt(2, 40);
    `CHK("disabled out", 0, c)
    cnt(1, 40);
    `CHK("half rate out", 1'b1, c >= 9 && c <= 11)
    $display("t_enables done");
  endtask : t_enables
  task automatic t_ratio;
    logic [31:0] w [4] = '{32'h0402_0900, 32'h0602_0000, 32'h0402_0A83, 32'h0402_0100};
    logic [31:0] e [4] = '{32'h0004_0009, 32'h000C_0010, 32'h0004_0005, 32'h0004_0000};
    for (int i = 0; i < 4; i++) begin
      halve <= (i == 1);
      bus(1'b1, SCGS_OFF_RWL, w[i]);
      // system and engine ratios register one cycle after the word
      cyc(2);
      bus(1'b0, SCGS_OFF_RAT, 32'h0);
      `CHK("ratio", e[i], rd)
      `CHK("invalid", i == 3, bad)
      `CHK("engine en", i != 3, eng_en)
    end
    halve <= 1'b0;
    $display("t_ratio done");
  endtask : t_ratio
  task automatic t_sec;
    bus(1'b1, SCGS_OFF_RWL, 32'h0402_0900);
    // third, half, full: 12, 18, 36 level changes in 36 cycles
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, SCGS_OFF_UCR, 32'h7 - i);
      cyc(4);
      cnt(5, 36);
      `CHK("sec rate", 12 + 6 * i + 12 * (i / 2), c)
    end
    bus(1'b1, SCGS_OFF_UCR, 32'h1);
    bus(1'b0, SCGS_OFF_UCR, 32'h0);
    `CHK("full ok", 32'h1, rd)
    bus(1'b1, SCGS_OFF_UCR, 32'h0);
    cyc(3);
    `CHK("dma off", 1'b0, dma_clk_en)
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      `CHK("sec off", 1'b0, sec_clk)
    end
    bus(1'b1, SCGS_OFF_RWL, 32'h0602_0900);
    bus(1'b1, SCGS_OFF_UCR, 32'h6);
    bus(1'b1, SCGS_OFF_UCR, 32'h5);
    bus(1'b0, SCGS_OFF_UCR, 32'h0);
    `CHK("full refused", 32'h6, rd)
    `CHK("dma on", 1'b1, dma_clk_en)
    $display("t_sec done");
  endtask : t_sec
  task automatic t_div;
    bus(1'b1, SCGS_OFF_LCR, 32'h0);
    cnt(3, 20);
    `CHK("lb stop", 0, c)
    bus(1'b1, SCGS_OFF_LCR, 32'h3);
    cyc(8);
    cnt(3, 30);
    `CHK("lb div3", 1'b1, c >= 9 && c <= 11)
    cnt(4, 20);
    `CHK("mem1 half", 20, c)
    $display("t_div done");
  endtask : t_div
  task automatic t_sync;
    bus(1'b1, SCGS_OFF_RWH, 32'hC000_0000);
    for (int h = 0; h < 2; h++) begin
      halve <= h[0];
      cyc(6);
      cnt(0, 40);
      `CHK("sync out", 1'b1, c >= 19 - 10 * h && c <= 21 - 10 * h)
    end
    halve <= 1'b0;
    $display("t_sync done");
  endtask : t_sync
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(1);
    t_reset();
    t_source();
    t_enables();
    t_ratio();
    t_sec();
    t_div();
    t_sync();
    summarize();
  end
endmodule : scgs_tb_top
